// *** rtl/i2cmd_pkg.sv ***
// Constants, field layout and types for the two-wire bus master.
// Assumes a 20 MHz functional clock and an 8-bit register address.
package i2cmd_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int RATE_STD = 100_000;
    localparam int RATE_FAST = 400_000;
    localparam int RATE_FMP = 1_000_000;
    localparam int RATE_HS = 3_200_000;
    // Period rounded up so no class runs faster than its rate
    localparam int PER_STD = (CLK_HZ + RATE_STD - 1) / RATE_STD;
    localparam int PER_FAST = (CLK_HZ + RATE_FAST - 1) / RATE_FAST;
    localparam int PER_FMP = (CLK_HZ + RATE_FMP - 1) / RATE_FMP;
    localparam int PER_HS = (CLK_HZ + RATE_HS - 1) / RATE_HS;
    localparam logic [15:0] HCNT_RST [4] = '{16'(PER_STD / 2), 16'(PER_FAST / 2),
                                             16'(PER_FMP / 2), 16'(PER_HS / 2)};
    localparam logic [15:0] LCNT_RST [4] = '{16'(PER_STD - PER_STD / 2), 16'(PER_FAST - PER_FAST / 2),
                                             16'(PER_FMP - PER_FMP / 2), 16'(PER_HS - PER_HS / 2)};
    localparam logic [15:0] HOLD_RST = 16'h0002;
    // Register offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_TAR = 8'h04;
    localparam logic [7:0] A_DATA = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0C;
    localparam logic [7:0] A_ISTAT = 8'h10;
    localparam logic [7:0] A_IMASK = 8'h14;
    localparam logic [7:0] A_SCL_BASE = 8'h20;
    localparam logic [7:0] A_SCL_MASK = 8'hE0;
    localparam logic [7:0] A_HOLD = 8'h40;
    localparam logic [7:0] A_RESET = 8'h44;
    localparam logic [7:0] A_DMA = 8'h48;
    localparam logic [7:0] A_BLOCK = 8'h4C;
    // Control fields
    localparam int F_EN = 0;
    localparam int F_A10 = 1;
    localparam int F_RS = 2;
    localparam int F_SPD = 3;
    localparam int F_MST = 5;
    localparam logic [5:0] CTRL_RST = 6'h20;
    // DMA control fields
    localparam int D_TXEN = 0;
    localparam int D_RXEN = 1;
    localparam int D_WID = 2;
    localparam int D_BL = 4;
    localparam int D_TERM = 7;
    // Interrupt bits
    localparam int I_STOP = 0;
    localparam int I_NACK = 1;
    localparam int I_DMA = 2;
    localparam int INT_W = 3;
    localparam logic [4:0] HDR10 = 5'h1E;
    localparam int FIFO_DEPTH = 64;
    localparam int DMA_MAX_BURST = 32;
    typedef struct packed {
        logic rd;
        logic [7:0] data;
    } i2cmd_cmd_type;
    typedef enum logic [3:0] {ST_IDLE, ST_START, ST_LOW, ST_HIGH, ST_RSTART, ST_RHIGH,
                              ST_STOP, ST_PHIGH, ST_BUF} i2cmd_state_type;
    typedef enum logic [1:0] {PH_ADDR, PH_ADDR2, PH_DATA} i2cmd_phase_type;
endpackage

// *** rtl/i2cmd_top.sv ***
// Two-wire bus master with 64-byte FIFOs and a DMA handshake channel.
// Assumes pull-ups on both lines and a DMA engine that moves one byte per beat.
// What this block does
// (RQ1) Standard, fast, fast plus and high-speed rates
// (RQ2) Master only, no slave or arbitration
// (RQ3) Seven or ten bit target addressing
// (RQ4) Software selects only one speed class
// (RQ5) Separate 64-byte transmit and receive FIFOs
// (RQ6) DMA FIFO 64 bytes, bursts at most 32
// (RQ7) Transaction opens with a START condition
// (RQ8) Address then direction bit shifted out
// (RQ9) Sample target acknowledge after address byte
// (RQ10) Bytes of eight bits, each acknowledged
// (RQ11) STOP ends message, idle lines high
// (RQ12) Combined transfers never mix address formats
// (RQ13) Software sets restart enable before combining
// (RQ14) Direction change with restart: repeated start
// (RQ15) Empty transmit FIFO at end: STOP
// (RQ16) DMA paced by handshake both directions
// (RQ17) DMA configured by register writes
// (RQ18) Widths 1, 2, 4; burst power of two (the width field here also takes code 3, 8 bytes)
// (RQ19) Byte block size, early termination, enables
// (RQ20) Held in reset until software releases
// (RQ21) Software idles controller before resetting it
// (RQ22) Level interrupt, cleared by register write
// (RQ23) Programmable clock high, low and hold counts
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module i2cmd_top import i2cmd_pkg::*; (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // DMA transmit handshake
    output logic dma_tx_req,
    input wire logic dma_tx_valid,
    input wire i2cmd_cmd_type dma_tx_data,
    output logic dma_tx_ready,
    // DMA receive handshake
    output logic dma_rx_req,
    input wire logic dma_rx_ack,
    output logic [7:0] dma_rx_data,
    // Serial pins
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Interrupt
    output logic irq
);
    logic [5:0] ctrl;
    logic [9:0] tar;
    logic [15:0] hcnt [4];
    logic [15:0] lcnt [4];
    logic [15:0] hold;
    logic [1:0] rst_reg;
    logic [9:0] dma_ctrl;
    logic [15:0] remain;
    logic [INT_W-1:0] istat;
    logic [INT_W-1:0] imask;
    i2cmd_cmd_type tx_mem [FIFO_DEPTH];
    logic [7:0] rx_mem [FIFO_DEPTH];
    logic [6:0] tx_wp, tx_rp, rx_wp, rx_rp, tx_cnt, rx_cnt;
    logic scl_m, scl_s, sda_m, sda_s;
    i2cmd_state_type st;
    i2cmd_phase_type phase;
    logic [15:0] tmr;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic held, cur_rd, hdr_rd, cur_a10, scl_o, sda_o;
    logic tx_pop, tx_flush, rx_push, ev_stop, ev_nack;
    logic run, dma_run, tdone, tx_empty, tx_full, rx_empty, rx_full;
    logic rd_byte, ack_more, bit_val, stall;
    logic [1:0] spd;
    logic [15:0] hsel, lrest;
    i2cmd_cmd_type tx_head;
    logic bus_push, bus_pop, dma_push, dma_pop, ev_dma;
    logic [8:0] burst;
    logic [10:0] burst_bytes;
    logic [15:0] need;

    default clocking dc @(posedge clk); endclocking
    default disable iff (!arst_n);

    assign run = rst_reg[0];
    assign dma_run = rst_reg[1];
    assign tx_cnt = tx_wp - tx_rp;
    assign rx_cnt = rx_wp - rx_rp;
    assign tx_empty = tx_cnt == 7'h00;
    assign tx_full = tx_cnt == 7'(FIFO_DEPTH);
    assign rx_empty = rx_cnt == 7'h00;
    assign rx_full = rx_cnt == 7'(FIFO_DEPTH);
    assign tx_head = tx_mem[tx_rp[5:0]];
    assign tdone = tmr == 16'h0000;
    assign spd = ctrl[F_SPD +: 2];
    assign hsel = hcnt[spd]; // RQ1
    assign lrest = (lcnt[spd] > hold) ? lcnt[spd] - hold : 16'h0001;
    assign rd_byte = (phase == PH_DATA) && cur_rd;
    assign ack_more = !tx_empty && tx_head.rd;
    assign stall = rd_byte && (bitn == 4'h0) && rx_full;
    // Open drain: enable high while pulling low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = !scl_o;
    assign sda_oe = !sda_o;

    always_comb begin
        if (bitn == 4'h8)
            bit_val = rd_byte ? !ack_more : 1'b1; // RQ10
        else
            bit_val = rd_byte ? 1'b1 : sh[7];
    end

    // Two-stage synchronisers for the pins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
        end else if (ce) begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            sda_m <= sda_in;
            sda_s <= sda_m;
        end
    end

    // Configuration registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= CTRL_RST;
            tar <= 10'h000;
            hcnt <= HCNT_RST;
            lcnt <= LCNT_RST;
            hold <= HOLD_RST;
            rst_reg <= 2'h0;
            dma_ctrl <= 10'h000;
            imask <= '0;
        end else if (ce && reg_wr) begin
            if (reg_addr == A_CTRL)
                ctrl <= {1'b1, reg_wdata[4:0]}; // RQ2
            if (reg_addr == A_TAR)
                tar <= reg_wdata[9:0];
            if ((reg_addr & A_SCL_MASK) == A_SCL_BASE && !reg_addr[2])
                hcnt[reg_addr[4:3]] <= reg_wdata[15:0]; // RQ23
            if ((reg_addr & A_SCL_MASK) == A_SCL_BASE && reg_addr[2])
                lcnt[reg_addr[4:3]] <= reg_wdata[15:0]; // RQ23
            if (reg_addr == A_HOLD)
                hold <= reg_wdata[15:0]; // RQ23
            if (reg_addr == A_RESET)
                rst_reg <= reg_wdata[1:0]; // RQ20
            if (reg_addr == A_DMA)
                dma_ctrl <= {reg_wdata[9:8], 1'b0, reg_wdata[6:0]}; // RQ18
            if (reg_addr == A_IMASK)
                imask <= reg_wdata[INT_W-1:0];
        end
    end

    // FIFOs; bus access wins over a DMA beat in the same cycle
    assign bus_push = reg_wr && reg_addr == A_DATA && !tx_full;
    assign bus_pop = reg_rd && reg_addr == A_DATA && !rx_empty;
    assign dma_tx_ready = dma_run && !tx_full && !(reg_wr && reg_addr == A_DATA); // RQ16
    assign dma_push = dma_tx_valid && dma_tx_ready;
    assign dma_pop = dma_run && dma_rx_ack && !rx_empty && !bus_pop; // RQ16
    assign dma_rx_data = rx_mem[rx_rp[5:0]];

    always_ff @(posedge clk) begin
        if (ce && (bus_push || dma_push))
            tx_mem[tx_wp[5:0]] <= bus_push ? i2cmd_cmd_type'(reg_wdata[8:0]) : dma_tx_data; // RQ5
        if (ce && rx_push)
            rx_mem[rx_wp[5:0]] <= sh; // RQ5
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_wp <= 7'h00;
            tx_rp <= 7'h00;
            rx_wp <= 7'h00;
            rx_rp <= 7'h00;
        end else if (ce) begin
            if (!run) begin
                tx_rp <= tx_wp;
                rx_rp <= rx_wp;
            end else begin
                if (bus_push || dma_push)
                    tx_wp <= tx_wp + 7'h01;
                if (tx_flush)
                    tx_rp <= tx_wp;
                else if (tx_pop)
                    tx_rp <= tx_rp + 7'h01;
                if (rx_push)
                    rx_wp <= rx_wp + 7'h01;
                if (bus_pop || dma_pop)
                    rx_rp <= rx_rp + 7'h01;
            end
        end
    end

    // Bus sequencer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= ST_IDLE;
            phase <= PH_ADDR;
            tmr <= 16'h0000;
            bitn <= 4'h0;
            sh <= 8'h00;
            held <= 1'b0;
            cur_rd <= 1'b0;
            hdr_rd <= 1'b0;
            cur_a10 <= 1'b0;
            scl_o <= 1'b1;
            sda_o <= 1'b1;
            tx_pop <= 1'b0;
            tx_flush <= 1'b0;
            rx_push <= 1'b0;
            ev_stop <= 1'b0;
            ev_nack <= 1'b0;
        end else if (ce) begin
            tx_pop <= 1'b0;
            tx_flush <= 1'b0;
            rx_push <= 1'b0;
            ev_stop <= 1'b0;
            ev_nack <= 1'b0;
            if (!tdone)
                tmr <= tmr - 16'h0001;
            if (!run) begin
                st <= ST_IDLE; // RQ20
                scl_o <= 1'b1;
                sda_o <= 1'b1;
            end else begin
                unique case (st)
                    ST_IDLE: begin
                        if (ctrl[F_EN] && !tx_empty && scl_s && sda_s) begin
                            cur_rd <= tx_head.rd;
                            cur_a10 <= ctrl[F_A10]; // RQ12
                            hdr_rd <= 1'b0;
                            sda_o <= 1'b0; // RQ7
                            tmr <= hsel;
                            st <= ST_START;
                        end
                    end
                    ST_START: begin
                        if (tdone) begin
                            scl_o <= 1'b0;
                            phase <= PH_ADDR;
                            if (cur_a10)
                                sh <= {HDR10, tar[9:8], hdr_rd}; // RQ3
                            else
                                sh <= {tar[6:0], cur_rd}; // RQ8
                            bitn <= 4'h0;
                            held <= 1'b0;
                            tmr <= hold;
                            st <= ST_LOW;
                        end
                    end
                    ST_LOW: begin
                        if (tdone && !held) begin
                            sda_o <= bit_val; // RQ23
                            held <= 1'b1;
                            tmr <= lrest;
                        end else if (tdone && !stall) begin
                            scl_o <= 1'b1;
                            tmr <= hsel;
                            st <= ST_HIGH;
                        end
                    end
                    ST_HIGH: begin
                        // Target stretching the clock restarts the high count
                        if (!scl_s) begin
                            tmr <= hsel;
                        end else if (tdone) begin
                            scl_o <= 1'b0;
                            held <= 1'b0;
                            tmr <= hold;
                            if (bitn != 4'h8) begin
                                sh <= {sh[6:0], sda_s};
                                bitn <= bitn + 4'h1;
                                st <= ST_LOW;
                            end else if (sda_s && !rd_byte) begin
                                ev_nack <= 1'b1; // RQ9
                                tx_flush <= 1'b1;
                                st <= ST_STOP;
                            end else begin
                                rx_push <= rd_byte;
                                bitn <= 4'h0;
                                if (phase == PH_ADDR && cur_a10 && !hdr_rd) begin
                                    sh <= tar[7:0]; // RQ3
                                    phase <= PH_ADDR2;
                                    st <= ST_LOW;
                                end else if (phase == PH_ADDR2 && cur_rd) begin
                                    hdr_rd <= 1'b1;
                                    st <= ST_RSTART;
                                end else if (tx_empty) begin
                                    st <= ST_STOP; // RQ15
                                end else if (tx_head.rd != cur_rd) begin
                                    // Direction change: repeated start if restart enabled, else finish and start afresh
                                    cur_rd <= tx_head.rd;
                                    hdr_rd <= 1'b0;
                                    st <= ctrl[F_RS] ? ST_RSTART : ST_STOP; // RQ14
                                end else begin
                                    phase <= PH_DATA;
                                    tx_pop <= 1'b1;
                                    // Finished read byte stays put until it lands in the receive FIFO
                                    if (!rd_byte)
                                        sh <= tx_head.data; // RQ10
                                    st <= ST_LOW;
                                end
                            end
                        end
                    end
                    ST_RSTART: begin
                        if (tdone && !held) begin
                            sda_o <= 1'b1;
                            held <= 1'b1;
                            tmr <= lrest;
                        end else if (tdone) begin
                            scl_o <= 1'b1;
                            tmr <= hsel;
                            st <= ST_RHIGH;
                        end
                    end
                    ST_RHIGH: begin
                        if (!scl_s) begin
                            tmr <= hsel;
                        end else if (tdone) begin
                            sda_o <= 1'b0; // RQ14
                            tmr <= hsel;
                            st <= ST_START;
                        end
                    end
                    ST_STOP: begin
                        if (tdone && !held) begin
                            sda_o <= 1'b0;
                            held <= 1'b1;
                            tmr <= lrest;
                        end else if (tdone) begin
                            scl_o <= 1'b1;
                            tmr <= hsel;
                            st <= ST_PHIGH;
                        end
                    end
                    ST_PHIGH: begin
                        if (!scl_s) begin
                            tmr <= hsel;
                        end else if (tdone) begin
                            sda_o <= 1'b1; // RQ11
                            tmr <= lcnt[spd];
                            st <= ST_BUF;
                        end
                    end
                    ST_BUF: begin
                        // Bus free time before a fresh START
                        if (tdone) begin
                            ev_stop <= 1'b1;
                            st <= ST_IDLE; // RQ15
                        end
                    end
                endcase
            end
        end
    end

    // DMA handshake: burst in bytes capped by the DMA FIFO burst limit
    always_comb begin
        // Wide enough for 128 items of 8 bytes, so the cap never sees a wrapped value
        burst_bytes = 11'(11'h001 << dma_ctrl[D_BL +: 3]) << dma_ctrl[D_WID +: 2]; // RQ18
        burst = (burst_bytes > 11'(DMA_MAX_BURST)) ? 9'(DMA_MAX_BURST) : burst_bytes[8:0]; // RQ6
        need = (remain < {7'h00, burst}) ? remain : {7'h00, burst};
    end

    assign dma_tx_req = dma_run && dma_ctrl[D_TXEN] && remain != 16'h0000
                        && (7'(FIFO_DEPTH) - tx_cnt) >= need[6:0]; // RQ16
    assign dma_rx_req = dma_run && dma_ctrl[D_RXEN] && remain != 16'h0000
                        && {9'h000, rx_cnt} >= need; // RQ16
    assign ev_dma = remain == 16'h0001 && (dma_push || dma_pop);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            remain <= 16'h0000;
        else if (ce) begin
            if (!dma_run)
                remain <= 16'h0000;
            else if (reg_wr && reg_addr == A_BLOCK)
                remain <= reg_wdata[15:0]; // RQ17
            else if (reg_wr && reg_addr == A_DMA && reg_wdata[D_TERM])
                remain <= 16'h0000; // RQ19
            else if ((dma_push || dma_pop) && remain != 16'h0000)
                remain <= remain - 16'h0001; // RQ19
        end
    end

    // Sticky status, write one to clear, a new event wins over the clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            istat <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            istat <= (istat & ~((reg_wr && reg_addr == A_ISTAT) ? reg_wdata[INT_W-1:0] : '0))
                     | {ev_dma, ev_nack, ev_stop}; // RQ22
            irq <= |(istat & imask); // RQ22
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            reg_rdata <= 32'h00000000;
        else if (ce && reg_rd) begin
            unique case (reg_addr)
                A_CTRL: reg_rdata <= {26'h0000000, ctrl};
                A_TAR: reg_rdata <= {22'h000000, tar};
                A_DATA: reg_rdata <= {24'h000000, rx_empty ? 8'h00 : dma_rx_data};
                A_STAT: reg_rdata <= {16'h0000, 2'h0, rx_cnt, tx_cnt[5:0], st != ST_IDLE};
                A_ISTAT: reg_rdata <= {29'h00000000, istat};
                A_IMASK: reg_rdata <= {29'h00000000, imask};
                A_HOLD: reg_rdata <= {16'h0000, hold};
                A_RESET: reg_rdata <= {30'h00000000, rst_reg};
                A_DMA: reg_rdata <= {22'h000000, dma_ctrl};
                A_BLOCK: reg_rdata <= {16'h0000, remain};
                default: reg_rdata <= ((reg_addr & A_SCL_MASK) == A_SCL_BASE)
                                      ? {16'h0000, reg_addr[2] ? lcnt[reg_addr[4:3]] : hcnt[reg_addr[4:3]]}
                                      : 32'h00000000;
            endcase
        end
    end

    sequence s_byte_end;
        ce && run && st == ST_HIGH && bitn == 4'h8 && scl_s && tdone;
    endsequence

    sequence s_ack_ok;
        !sda_s || rd_byte;
    endsequence

    a_start_cond: assert property (ce && st == ST_START |-> !scl_oe && sda_oe) // RQ7
        else $error("START not held");
    a_addr_nack: assert property (s_byte_end ##0 (sda_s && !rd_byte) |=> st == ST_STOP && tx_flush) // RQ9
        else $error("missing stop after nack");
    a_empty_stop: assert property (s_byte_end ##0 s_ack_ok ##0 (phase == PH_DATA && tx_empty)
                                   |=> st == ST_STOP) // RQ15
        else $error("empty fifo did not stop");
    a_dir_restart: assert property (s_byte_end ##0 s_ack_ok ##0 (phase == PH_DATA && !tx_empty
                                    && tx_head.rd != cur_rd && ctrl[F_RS]) |=> st == ST_RSTART) // RQ14
        else $error("no repeated start");
    a_stop_edge: assert property (ce && run && st == ST_PHIGH && scl_s && tdone
                                  |=> !sda_oe && !scl_oe && st == ST_BUF) // RQ11
        else $error("stop edge wrong");
    a_soft_rst: assert property (ce && !run |=> st == ST_IDLE && !scl_oe && !sda_oe) // RQ20
        else $error("soft reset not idle");
    a_irq_level: assert property (ce |=> irq == |($past(istat) & $past(imask))) // RQ22
        else $error("irq not level of status");
    a_fifo_cap: assert property (tx_cnt <= 7'(FIFO_DEPTH) && rx_cnt <= 7'(FIFO_DEPTH)) // RQ5
        else $error("fifo overrun");
    a_burst_cap: assert property (burst <= 9'(DMA_MAX_BURST) && burst != 9'h000) // RQ6
        else $error("burst too long");
    a_high_count: assert property (ce && run && st == ST_LOW && held && tdone && !stall
                                   |=> st == ST_HIGH && tmr == $past(hsel)) // RQ23
        else $error("high count not loaded");
endmodule // i2cmd_top
`default_nettype wire

// *** verification/i2cmd_target.sv ***
// Behavioural bus target: acks its own address, returns a fixed byte on reads.
// Assumes pull-ups on both lines; only ever pulls the data line low.
`timescale 1ns/10ps
`default_nettype none
module i2cmd_target #(parameter logic [6:0] ADDR = 7'h2A, parameter logic [7:0] RDATA = 8'hC5) (
    // Bus lines
    input wire logic scl,
    input wire logic sda,
    output logic sda_pull,
    // Last data byte written on the bus, whether or not it was addressed to us
    output logic [7:0] got
);
    logic [3:0] bit_n = 4'h0;
    logic [7:0] sh = 8'h00;
    logic first = 1'b0;
    logic rd = 1'b0;
    logic hit = 1'b0;
    initial sda_pull = 1'b0;
    initial got = 8'h00;
    always @(negedge sda) if (scl) begin
        // Next falling clock ends the START itself, not a bit
        bit_n = 4'hF;
        first = 1'b1;
    end
    always @(posedge scl) begin
        // Master nack ends a read, so let go before its STOP
        if (bit_n == 4'h8 && rd && !first && sda) hit = 1'b0;
        sh = {sh[6:0], sda};
    end
    always @(negedge scl) begin
        bit_n = bit_n + 4'h1;
        if (bit_n == 4'h9) begin
            bit_n = 4'h0;
            first = 1'b0;
        end
        if (bit_n == 4'h8 && first) begin
            hit = (sh[7:1] == ADDR);
            rd = sh[0];
        end
        if (bit_n == 4'h8 && !first && !rd) got = sh;
        if (bit_n == 4'h8) sda_pull = hit && (first || !rd);
        else sda_pull = hit && rd && !first && !RDATA[3'h7 - bit_n[2:0]];
    end
endmodule // i2cmd_target
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench: register port stimulus, behavioural target on the lines.
// Assumes pull-ups on both lines; DMA receive handshake held idle, one DMA transmit beat driven.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import i2cmd_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, scl_oe, sda_oe, sda_pull, irq;
    logic dma_v = 1'b0, dma_req;
    logic [7:0] reg_addr = 8'h00, got, wb;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    int error_cnt = 0, total_checks = 0, starts = 0, stops = 0;
    wire logic scl_w = !scl_oe;
    wire logic sda_w = !(sda_oe || sda_pull);
    always #25 clk = ~clk;
    always @(negedge sda_w) if (scl_w) starts++;
    always @(posedge sda_w) if (scl_w) stops++;
    i2cmd_top i_i2cmd_top (.clk(clk), .arst_n(arst_n), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_tx_req(dma_req), .dma_tx_valid(dma_v),
        .dma_tx_data(9'h05A), .dma_tx_ready(), .dma_rx_req(), .dma_rx_ack(1'b0), .dma_rx_data(),
        .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe), .irq(irq));
    i2cmd_target i_i2cmd_target (.scl(scl_w), .sda(sda_w), .sda_pull(sda_pull), .got(got));
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk);
    endtask
    // Bounded poll: busy low and transmit queue empty
    task automatic wait_idle;
        d = 32'h1;
        for (int i = 0; i < 4000 && d[6:0] !== 7'h00; i++) rd(A_STAT);
        // Status and interrupt trail the idle state by two registers
        repeat (2) @(posedge clk);
        chk(d[6:0], 7'h00);
    endtask
    task automatic tally_and_finish;
        if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #3_000_000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(33130));
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        chk({scl_oe, sda_oe, irq}, 3'h0);
        rd(A_RESET);
        chk(d, 32'h0);
        rd(A_CTRL);
        chk(d, 32'h20);
        rd(8'hFC);
        chk(d, 32'h0);
        wr(A_DATA, 32'h0AA);
        rd(A_STAT);
        chk(d[6:1], 6'h00);
        wr(A_RESET, 32'h3);
        wr(A_TAR, 32'h2A);
        wr(A_IMASK, 32'h7);
        for (int rs = 0; rs < 2; rs++) begin
            wb = 8'($urandom);
            wr(A_CTRL, 32'h01 | (rs << F_RS) | (($urandom % 3 + 1) << F_SPD));
            starts = 0;
            stops = 0;
            wr(A_DATA, {24'h0, wb});
            wr(A_DATA, 32'h100);
            wait_idle;
            chk(got, wb);
            chk(starts, 2);
            chk(stops, 2 - rs);
            chk(irq, 1'b1);
            rd(A_DATA);
            chk(d, 32'hC5);
            rd(A_ISTAT);
            chk(d[0], 1'b1);
            wr(A_ISTAT, 32'h7);
            @(posedge clk);
            chk(irq, 1'b0);
        end
        wr(A_TAR, 32'h15);
        wr(A_DATA, 32'h33);
        wait_idle;
        rd(A_ISTAT);
        chk(d[1], 1'b1);
        chk({scl_oe, sda_oe}, 2'h0);
        wr(A_TAR, 32'h2A);
        wr(A_DMA, 32'h01);
        wr(A_BLOCK, 32'h1);
        chk(dma_req, 1'b1);
        dma_v <= 1'b1;
        @(posedge clk);
        dma_v <= 1'b0;
        wait_idle;
        chk(got, 8'h5A);
        chk(dma_req, 1'b0);
        rd(A_ISTAT);
        chk(d[2], 1'b1);
        wr(A_RESET, 32'h0);
        rd(A_STAT);
        chk(d, 32'h0);
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
